// ===== dv/fes_fpu_model.sv
// Behavioural floating-point datapath: issues operations, then completes them.
// Assumes the status block takes an issue on any edge while it is not trap-held and its queue is not full.
module fes_fpu_model (
   // Clock
   input wire logic i_clk,
   // Issue side
   output logic o_issue,
   output logic [31:0] o_instr,
   output logic [31:0] o_addr,
   // Completion side
   output logic o_cmpl,
   output logic [8:0] o_ind
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      o_issue = 1'b0;
      o_instr = 32'h0000_0000;
      o_addr = 32'h0000_0000;
      o_cmpl = 1'b0;
      o_ind = 9'h000;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // One operation: issue, optional delay, completion; released lines invert
   task automatic run(input logic [8:0] d, input logic [31:0] ins, input logic [31:0] ad,
                      input int gap);
      @(posedge i_clk);
      o_issue <= 1'b1;
      o_instr <= ins;
      o_addr <= ad;
      @(posedge i_clk);
      o_issue <= 1'b0;
      o_instr <= ~ins;
      o_addr <= ~ad;
      repeat (gap) @(posedge i_clk);
      o_cmpl <= 1'b1;
      o_ind <= d;
      @(posedge i_clk);
      o_cmpl <= 1'b0;
      o_ind <= ~d;
   endtask : run
endmodule : fes_fpu_model

// ===== dv/tb.sv
// Self-checking bench for the exception status block with a datapath model.
// Assumes one fes_status with queue and full conformance, one without queue.
`define CHK(nm, ex, gt) begin \
   cmp_count++; \
   if ((gt) !== (ex)) begin \
      n_mismatch++; \
      $display("[FAIL] %s exp=%h got=%h", nm, ex, gt); \
   end \
end
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic i_clk, i_rst, i_wr, i_rd, rd_d, issue, ready, cmpl, o_fp_trap, o_qne;
   logic [3:0] i_addr;
   logic [31:0] i_wdata, o_rdata, instr, iaddr, l_ins, l_addr, ex;
   logic [8:0] ind;
   logic [2:0] o_trap_type, e_ftt;
   logic [4:0] e_mask, e_aexc, e_cexc;
   logic e_qne;
   logic o2_trap, o2_qne;
   logic [2:0] o2_type;
   logic [7:0] seed, r;
   logic [31:0] exp_q[$];
   logic [8:0] dir [9] = '{9'h100, 9'h080, 9'h050, 9'h048, 9'h060, 9'h007, 9'h106, 9'h010,
                           9'h000};
   logic [8:0] trp [5] = '{9'h010, 9'h007, 9'h040, 9'h080, 9'h100};
   int n_mismatch, cmp_count, cyc;

   fes_status #(.QUEUE_EN(1'b1), .QDEPTH(4), .CONFORM_MASK(5'h1F)) DUT (
      .i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
      .i_rd(i_rd), .o_rdata(o_rdata), .i_issue(issue), .i_issue_instr(instr),
      .i_issue_addr(iaddr), .o_issue_ready(ready), .i_cmpl(cmpl), .i_improper(ind[8]),
      .i_ovf(ind[7]), .i_tiny(ind[6]), .i_exact_zero(ind[5]), .i_inexact(ind[4]),
      .i_round_min_norm(ind[3]), .i_is_div(ind[2]), .i_divisor_zero(ind[1]),
      .i_dividend_finite_nz(ind[0]), .o_fp_trap(o_fp_trap), .o_trap_type(o_trap_type),
      .o_qne(o_qne));
   // No queue, only the inexact bits conformant
   fes_status #(.QUEUE_EN(1'b0), .QDEPTH(4), .CONFORM_MASK(5'h01)) DUT2 (
      .i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
      .i_rd(i_rd), .o_rdata(), .i_issue(issue), .i_issue_instr(instr),
      .i_issue_addr(iaddr), .o_issue_ready(), .i_cmpl(cmpl), .i_improper(ind[8]),
      .i_ovf(ind[7]), .i_tiny(ind[6]), .i_exact_zero(ind[5]), .i_inexact(ind[4]),
      .i_round_min_norm(ind[3]), .i_is_div(ind[2]), .i_divisor_zero(ind[1]),
      .i_dividend_finite_nz(ind[0]), .o_fp_trap(o2_trap), .o_trap_type(o2_type),
      .o_qne(o2_qne));
   fes_fpu_model u_fpu (.i_clk(i_clk), .o_issue(issue), .o_instr(instr), .o_addr(iaddr),
      .o_cmpl(cmpl), .o_ind(ind));

   always #5 i_clk = ~i_clk;

   ////////////////////////////////////////////////////////////////////////////////
   // Read data watcher and timeout
   always @(posedge i_clk) rd_d <= i_rd;
   always @(negedge i_clk) begin
      if (rd_d) begin
         ex = exp_q.pop_front();
         `CHK("rdata", ex, o_rdata)
      end
   end
   always @(posedge i_clk) begin
      cyc++;
      if (cyc >= 5000) begin
         n_mismatch++;
         final_report();
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Helpers
   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction : lfsr
   function automatic logic [4:0] exc_of(input logic [8:0] d, input logic uf_mask);
      logic uf;
      uf = d[6] & ~d[5] & (uf_mask | d[4] | d[3]);
      return {d[8], d[7], uf, d[2] & d[1] & d[0], d[4] | (uf & ~uf_mask)};
   endfunction : exc_of
   function automatic logic [31:0] sw();
      return {4'h0, e_mask, 6'h00, e_ftt, e_qne, 3'h0, e_aexc, e_cexc};
   endfunction : sw
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge i_clk);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_clk);
      i_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [3:0] a, input logic [31:0] e);
      @(posedge i_clk);
      i_rd <= 1'b1;
      i_addr <= a;
      exp_q.push_back(e);
      @(posedge i_clk);
      i_rd <= 1'b0;
   endtask : rd
   task automatic wstat(input logic [4:0] m, input logic [4:0] a);
      wr(fes_pkg::ADDR_STATUS, {4'h0, m, 6'h00, 4'h0, 3'h0, a, 5'h00});
      e_mask = m;
      e_aexc = a;
      e_cexc = 5'h00;
   endtask : wstat
   // Status load followed at once by a status read
   task automatic wload(input logic [31:0] w);
      @(posedge i_clk);
      i_wr <= 1'b1;
      i_addr <= fes_pkg::ADDR_STATUS;
      i_wdata <= w;
      e_mask = w[fes_pkg::TMASK_LSB +: fes_pkg::EXC_W];
      e_aexc = w[fes_pkg::AEXC_LSB +: fes_pkg::EXC_W];
      e_cexc = w[fes_pkg::CEXC_LSB +: fes_pkg::EXC_W];
      @(posedge i_clk);
      i_wr <= 1'b0;
      i_rd <= 1'b1;
      exp_q.push_back(sw());
      @(posedge i_clk);
      i_rd <= 1'b0;
   endtask : wload
   task automatic op(input logic [8:0] d, input int gap);
      logic [4:0] x;
      logic [4:0] t;
      logic [4:0] h;
      x = exc_of(d, e_mask[fes_pkg::BIT_UF]);
      t = x & e_mask;
      h = 5'h00;
      for (int i = 0; i < 5; i++) begin
         if (t[i]) begin
            h = 5'h01 << i;
         end
      end
      l_ins = {seed, 15'h0000, d};
      l_addr = {24'h0000F0, seed};
      u_fpu.run(d, l_ins, l_addr, gap);
      #1;
      `CHK("fp_trap", t != 5'h00, o_fp_trap)
      if (t != 5'h00) begin
         e_ftt = fes_pkg::FTT_IEEE;
         e_cexc = h;
         e_qne = 1'b1;
      end else begin
         e_ftt = fes_pkg::FTT_NONE;
         e_cexc = x;
         e_aexc = e_aexc | x;
         e_qne = 1'b0;
      end
   endtask : op
   task automatic final_report;
      $display("Comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : final_report

   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      i_clk = 1'b0;
      i_rst = 1'b1;
      i_addr = 4'h0;
      i_wdata = 32'h0000_0000;
      i_wr = 1'b0;
      i_rd = 1'b0;
      rd_d = 1'b0;
      {e_mask, e_aexc, e_cexc, e_ftt, e_qne} = 19'h00000;
      seed = 8'h5E;
      n_mismatch = 0;
      cmp_count = 0;
      cyc = 0;
      repeat (5) @(posedge i_clk);
      i_rst <= 1'b0;
      rd(fes_pkg::ADDR_STATUS, sw());
      #1;
      `CHK("issue_ready", 1'b1, ready)
      foreach (dir[k]) begin
         op(dir[k], 0);
         rd(fes_pkg::ADDR_STATUS, sw());
      end
      repeat (30) begin
         seed = lfsr(seed);
         r = seed;
         seed = lfsr(seed);
         op({r[0], seed}, int'(r[2:1]));
         rd(fes_pkg::ADDR_STATUS, sw());
      end
      $display("Classification test done");
      for (int i = 0; i < 5; i++) begin
         wstat(5'h01 << i, 5'h03);
         op(trp[i], 1);
         `CHK("trap_type", fes_pkg::FTT_IEEE, o_trap_type)
         `CHK("qne", 1'b1, o_qne)
         `CHK("issue_ready", 1'b0, ready)
         rd(fes_pkg::ADDR_STATUS, sw());
         rd(fes_pkg::ADDR_QINSTR, l_ins);
         rd(fes_pkg::ADDR_QADDR, l_addr);
         e_qne = 1'b0;
         rd(fes_pkg::ADDR_QADDR, fes_pkg::WORD_ZERO);
         #1;
         `CHK("seq_trap", 1'b1, o_fp_trap)
         `CHK("seq_type", fes_pkg::FTT_SEQ, o_trap_type)
         `CHK("seq_trap_noq", 1'b1, o2_trap)
         `CHK("seq_type_noq", fes_pkg::FTT_SEQ, o2_type)
         `CHK("qne_noq", 1'b0, o2_qne)
         e_ftt = fes_pkg::FTT_SEQ;
         rd(fes_pkg::ADDR_STATUS, sw());
      end
      $display("Trap and queue test done");
      wstat(5'h00, 5'h00);
      #1;
      `CHK("issue_ready", 1'b1, ready)
      op(9'h080, 0);
      `CHK("unfin_trap", 1'b1, o2_trap)
      `CHK("unfin_type", fes_pkg::FTT_UNFIN, o2_type)
      wload(32'h0AAA_AAAA);
      wr(4'hC, 32'hFFFF_FFFF);
      rd(4'hC, fes_pkg::WORD_ZERO);
      rd(fes_pkg::ADDR_STATUS, sw());
      $display("Register port test done");
      repeat (3) @(posedge i_clk);
      final_report();
   end
endmodule : tb

// ===== hw/fes_classify.sv
// Classifies one completed operation into the five exception flags.
// Assumes the datapath reports exact-result indicators in the completion cycle.
module fes_classify (
   // Result indicators
   input wire logic i_improper,
   input wire logic i_ovf,
   input wire logic i_tiny,
   input wire logic i_exact_zero,
   input wire logic i_inexact,
   input wire logic i_round_min_norm,
   input wire logic i_is_div,
   input wire logic i_divisor_zero,
   input wire logic i_dividend_finite_nz,
   // Underflow trap mask
   input wire logic i_uf_mask,
   // Flags out
   output logic [4:0] o_exc
);
   logic uf_raw;
   logic uf;

   // Never underflow on an exact zero result
   assign uf_raw = i_tiny & ~i_exact_zero; // RL3
   // Masked trap: any tiny result; else tiny and inexact or rounded to min normal
   assign uf = uf_raw & (i_uf_mask | i_inexact | i_round_min_norm); // RL4 RL5 RL7

   always_comb begin
      o_exc = fes_pkg::EXC_NONE;
      o_exc[fes_pkg::BIT_NV] = i_improper; // RL1 RL21
      o_exc[fes_pkg::BIT_OF] = i_ovf; // RL2
      o_exc[fes_pkg::BIT_UF] = uf;
      o_exc[fes_pkg::BIT_DZ] = i_is_div & i_divisor_zero & i_dividend_finite_nz; // RL8
      o_exc[fes_pkg::BIT_NX] = i_inexact | (uf & ~i_uf_mask); // RL9 RL6
   end
endmodule : fes_classify

// ===== hw/fes_pkg.sv
// Constants for the floating-point exception status block.
// Assumes a 32-bit plain register port and a five-flag exception vector.
package fes_pkg;
   // Exception vector width and bit order, most to least significant
   localparam int EXC_W = 5;
   localparam int BIT_NV = 4;
   localparam int BIT_OF = 3;
   localparam int BIT_UF = 2;
   localparam int BIT_DZ = 1;
   localparam int BIT_NX = 0;
   localparam logic [4:0] EXC_NONE = 5'h00;
   localparam logic [4:0] EXC_ALL = 5'h1F;
   localparam logic [4:0] EXC_NX_ONLY = 5'h01;
   ////////////////////////////////////////////////////////////////////////////////
   // Status word field positions
   localparam int CEXC_LSB = 0;
   localparam int AEXC_LSB = 5;
   localparam int QNE_BIT = 13;
   localparam int FTT_LSB = 14;
   localparam int TMASK_LSB = 23;
   localparam int FTT_W = 3;
   ////////////////////////////////////////////////////////////////////////////////
   // Trap type codes
   localparam logic [2:0] FTT_NONE = 3'h0;
   localparam logic [2:0] FTT_IEEE = 3'h1;
   localparam logic [2:0] FTT_UNFIN = 3'h2;
   localparam logic [2:0] FTT_SEQ = 3'h4;
   ////////////////////////////////////////////////////////////////////////////////
   // Register port map
   localparam int ADDR_W = 4;
   localparam int DATA_W = 32;
   localparam logic [3:0] ADDR_STATUS = 4'h0;
   localparam logic [3:0] ADDR_QADDR = 4'h4;
   localparam logic [3:0] ADDR_QINSTR = 4'h8;
   localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
   localparam logic [4:0] TMASK_RST = 5'h00;
   localparam logic [4:0] AEXC_RST = 5'h00;
   localparam logic [4:0] CEXC_RST = 5'h00;
endpackage : fes_pkg

// ===== hw/fes_status.sv
// Floating-point exception status, trap decision and deferred-trap queue.
// Assumes the datapath issues and completes operations in order on i_clk.
//
// How it works
// RL1: Invalid flag set for improper operands such as 0/0, else clear.
// RL2: Overflow flag set when rounded result exceeds largest normal.
// RL3: No underflow flag or trap when exact unrounded result is zero.
// RL4: Mask clear: tiny and inexact sets current and accrued underflow.
// RL5: Mask clear: tiny rounding to exactly min normal also sets underflow.
// RL6: Underflow with mask clear also sets current and accrued inexact.
// RL7: Mask set: any tiny nonzero result raises an IEEE trap.
// RL8: Divide-by-zero only for nonzero finite dividend over zero.
// RL9: Inexact flag set when rounded result differs from exact result.
// RL10: Inexact mask, current and accrued bits are always conformant.
// RL11: Nonconformant bits become state bits; their exception raises unfinished trap.
// RL12: State bits read back exactly what the status load wrote.
// RL13: Concurrent execution requires the deferred-trap queue to be present.
// RL14: Synchronous execution may omit the deferred-trap queue.
// RL15: Store-double-queue read port returns queue entries.
// RL16: Each entry keeps instruction word and address to recover operation.
// RL17: No queue: queue-not-empty reads 0, queue read traps type 4.
// RL18: Mask AND current nonzero traps, else current ORs into accrued.
// RL19: Current field is bits 4..0, cleared where no exception occurred.
// RL20: Accrued field is bits 9..5, accumulating masked exceptions.
// RL21: Field bit order is invalid, overflow, underflow, divide, inexact.
module fes_status #(
   parameter bit QUEUE_EN = 1'b1,
   parameter int QDEPTH = 4,
   parameter logic [4:0] CONFORM_MASK = 5'h1F
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   // Register port
   input wire logic [3:0] i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [31:0] o_rdata,
   // Issue side
   input wire logic i_issue,
   input wire logic [31:0] i_issue_instr,
   input wire logic [31:0] i_issue_addr,
   output logic o_issue_ready,
   // Completion side
   input wire logic i_cmpl,
   input wire logic i_improper,
   input wire logic i_ovf,
   input wire logic i_tiny,
   input wire logic i_exact_zero,
   input wire logic i_inexact,
   input wire logic i_round_min_norm,
   input wire logic i_is_div,
   input wire logic i_divisor_zero,
   input wire logic i_dividend_finite_nz,
   // Trap side
   output logic o_fp_trap,
   output logic [2:0] o_trap_type,
   output logic o_qne
);
   localparam int PTR_W = (QDEPTH > 1) ? $clog2(QDEPTH) : 1;
   localparam logic [PTR_W:0] CNT_MAX = (PTR_W + 1)'(QDEPTH);
   localparam logic [PTR_W:0] CNT_ZERO = '0;
   localparam logic [PTR_W:0] CNT_ONE = (PTR_W + 1)'(1);
   localparam logic [PTR_W-1:0] PTR_ONE = PTR_W'(1);

   // Elaboration checks
   generate
      if (QDEPTH < 2 || (QDEPTH & (QDEPTH - 1)) != 0) begin : g_bad_depth
         $error("QDEPTH must be a power of two of at least 2");
      end
      if (!CONFORM_MASK[fes_pkg::BIT_NX]) begin : g_bad_conform
         $error("Inexact bits must be conformant"); // RL10
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////////
   // Status fields
   logic [4:0] tmask_ff;
   logic [4:0] aexc_ff;
   logic [4:0] cexc_ff;
   logic [2:0] ftt_ff;
   logic trap_hold_ff;
   logic trap_ff;
   logic [31:0] rdata_ff;

   // Queue storage
   logic [31:0] q_instr_ff [QDEPTH];
   logic [31:0] q_addr_ff [QDEPTH];
   logic [PTR_W-1:0] wr_ptr_ff;
   logic [PTR_W-1:0] rd_ptr_ff;
   logic [PTR_W:0] count_ff;

   logic [4:0] exc;
   logic [4:0] trap_en;
   logic [4:0] nonconf;
   logic cmpl_take;
   logic unfin;
   logic ieee;
   logic clean;
   logic q_read;
   logic seq_err;
   logic any_trap;
   logic wr_status;
   logic push;
   logic pop;
   logic q_empty;

   // Highest-priority set bit, one-hot
   function automatic logic [4:0] first_bit(input logic [4:0] v);
      logic [4:0] r;
      r = fes_pkg::EXC_NONE;
      for (int i = fes_pkg::EXC_W - 1; i >= 0; i--) begin
         if (v[i] && r == fes_pkg::EXC_NONE) begin
            r[i] = 1'b1;
         end
      end
      return r;
   endfunction : first_bit

   // Status word assembly
   function automatic logic [31:0] status_word(input logic [4:0] tmask, input logic [2:0] ftt,
                                               input logic qne, input logic [4:0] aexc,
                                               input logic [4:0] cexc);
      logic [31:0] w;
      w = fes_pkg::WORD_ZERO;
      w[fes_pkg::TMASK_LSB +: fes_pkg::EXC_W] = tmask;
      w[fes_pkg::FTT_LSB +: fes_pkg::FTT_W] = ftt;
      w[fes_pkg::QNE_BIT] = qne;
      w[fes_pkg::AEXC_LSB +: fes_pkg::EXC_W] = aexc; // RL20
      w[fes_pkg::CEXC_LSB +: fes_pkg::EXC_W] = cexc; // RL19
      return w;
   endfunction : status_word

   ////////////////////////////////////////////////////////////////////////////////
   // Classification
   fes_classify u_classify (
      .i_improper(i_improper),
      .i_ovf(i_ovf),
      .i_tiny(i_tiny),
      .i_exact_zero(i_exact_zero),
      .i_inexact(i_inexact),
      .i_round_min_norm(i_round_min_norm),
      .i_is_div(i_is_div),
      .i_divisor_zero(i_divisor_zero),
      .i_dividend_finite_nz(i_dividend_finite_nz),
      .i_uf_mask(tmask_ff[fes_pkg::BIT_UF]),
      .o_exc(exc)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Trap decision
   assign q_empty = (count_ff == CNT_ZERO);
   assign trap_en = tmask_ff & exc; // RL18
   assign nonconf = exc & ~CONFORM_MASK; // RL11
   assign cmpl_take = i_cmpl & ~trap_hold_ff;
   assign unfin = cmpl_take & (|nonconf); // RL11
   assign ieee = cmpl_take & ~(|nonconf) & (|trap_en); // RL18 RL7
   assign clean = cmpl_take & ~unfin & ~ieee;
   assign q_read = i_rd & (i_addr == fes_pkg::ADDR_QADDR); // RL15
   assign seq_err = q_read & (!QUEUE_EN || q_empty); // RL17
   assign any_trap = unfin | ieee | seq_err;
   assign wr_status = i_wr & (i_addr == fes_pkg::ADDR_STATUS);

   // Trap mask, written by status load only
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         tmask_ff <= fes_pkg::TMASK_RST;
      end else if (wr_status) begin
         tmask_ff <= i_wdata[fes_pkg::TMASK_LSB +: fes_pkg::EXC_W]; // RL12
      end
   end

   // Current field: hardware events win over a same-cycle load
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         cexc_ff <= fes_pkg::CEXC_RST;
      end else if (clean) begin
         cexc_ff <= exc; // RL19
      end else if (ieee) begin
         cexc_ff <= first_bit(trap_en); // RL18
      end else if (wr_status && !unfin) begin
         cexc_ff <= i_wdata[fes_pkg::CEXC_LSB +: fes_pkg::EXC_W]; // RL12
      end
   end

   // Accrued field
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         aexc_ff <= fes_pkg::AEXC_RST;
      end else if (clean) begin
         aexc_ff <= (wr_status ? i_wdata[fes_pkg::AEXC_LSB +: fes_pkg::EXC_W] : aexc_ff)
                    | exc; // RL18 RL20
      end else if (wr_status && !ieee && !unfin) begin
         aexc_ff <= i_wdata[fes_pkg::AEXC_LSB +: fes_pkg::EXC_W]; // RL12
      end
   end

   // Trap type, untouched by status load
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         ftt_ff <= fes_pkg::FTT_NONE;
      end else if (seq_err) begin
         ftt_ff <= fes_pkg::FTT_SEQ; // RL17
      end else if (unfin) begin
         ftt_ff <= fes_pkg::FTT_UNFIN; // RL11
      end else if (ieee) begin
         ftt_ff <= fes_pkg::FTT_IEEE; // RL18
      end else if (clean) begin
         ftt_ff <= fes_pkg::FTT_NONE;
      end
   end

   // Trap pulse and hold until software reloads status
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         trap_ff <= 1'b0;
         trap_hold_ff <= 1'b0;
      end else begin
         trap_ff <= any_trap;
         if (any_trap) begin
            trap_hold_ff <= 1'b1;
         end else if (wr_status) begin
            trap_hold_ff <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Deferred-trap queue
   assign push = QUEUE_EN & i_issue & o_issue_ready; // RL13 RL16
   assign pop = QUEUE_EN & ~q_empty & (clean | (q_read & trap_hold_ff)); // RL15

   always_ff @(posedge i_clk) begin
      if (push) begin
         q_instr_ff[wr_ptr_ff] <= i_issue_instr; // RL16
         q_addr_ff[wr_ptr_ff] <= i_issue_addr;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         wr_ptr_ff <= '0;
         rd_ptr_ff <= '0;
         count_ff <= CNT_ZERO;
      end else begin
         if (push) begin
            wr_ptr_ff <= wr_ptr_ff + PTR_ONE;
         end
         if (pop) begin
            rd_ptr_ff <= rd_ptr_ff + PTR_ONE;
         end
         if (push && !pop) begin
            count_ff <= count_ff + CNT_ONE;
         end else if (pop && !push) begin
            count_ff <= count_ff - CNT_ONE;
         end
      end
   end

   // Without a queue, issue is gated by the trap hold only
   assign o_issue_ready = ~trap_hold_ff & (!QUEUE_EN || count_ff < CNT_MAX); // RL14
   assign o_qne = QUEUE_EN & ~q_empty; // RL17

   ////////////////////////////////////////////////////////////////////////////////
   // Read data, one cycle after the strobe
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         rdata_ff <= fes_pkg::WORD_ZERO;
      end else if (i_rd) begin
         unique case (i_addr)
            fes_pkg::ADDR_STATUS: begin
               rdata_ff <= status_word(tmask_ff, ftt_ff, o_qne, aexc_ff, cexc_ff);
            end
            fes_pkg::ADDR_QADDR: begin
               rdata_ff <= seq_err ? fes_pkg::WORD_ZERO : q_addr_ff[rd_ptr_ff]; // RL15
            end
            fes_pkg::ADDR_QINSTR: begin
               rdata_ff <= (QUEUE_EN && !q_empty) ? q_instr_ff[rd_ptr_ff]
                                                  : fes_pkg::WORD_ZERO;
            end
            default: begin
               rdata_ff <= fes_pkg::WORD_ZERO;
            end
         endcase
      end else begin
         rdata_ff <= fes_pkg::WORD_ZERO;
      end
   end

   assign o_rdata = rdata_ff;
   assign o_fp_trap = trap_ff;
   assign o_trap_type = ftt_ff;

   ////////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_rst);

   chk_cexc_clean: assert property ( // RL19
      clean |=> cexc_ff == $past(exc))
      else $error("current field not loaded from clean operation");
   chk_aexc_accum: assert property ( // RL20
      clean && !wr_status |=> aexc_ff == ($past(aexc_ff) | $past(exc)))
      else $error("accrued field did not accumulate");
   chk_ieee_trap: assert property ( // RL18
      ieee |=> o_fp_trap && o_trap_type == fes_pkg::FTT_IEEE && $onehot(cexc_ff)
               && aexc_ff == $past(aexc_ff))
      else $error("masked exception did not trap correctly");
   chk_no_zero_uf: assert property ( // RL3
      i_exact_zero |-> !exc[fes_pkg::BIT_UF])
      else $error("underflow on exact zero result");
   chk_uf_sets_nx: assert property ( // RL6
      exc[fes_pkg::BIT_UF] && !tmask_ff[fes_pkg::BIT_UF] |-> exc[fes_pkg::BIT_NX])
      else $error("underflow without inexact");
   chk_uf_trap: assert property ( // RL7
      cmpl_take && i_tiny && !i_exact_zero && tmask_ff[fes_pkg::BIT_UF]
      |=> o_fp_trap)
      else $error("tiny result did not trap with mask set");
   chk_dz_dividend: assert property ( // RL8
      !i_dividend_finite_nz |-> !exc[fes_pkg::BIT_DZ])
      else $error("divide-by-zero with zero or non-finite dividend");
   chk_unfin_trap: assert property ( // RL11
      unfin |=> o_trap_type == fes_pkg::FTT_UNFIN && cexc_ff == $past(cexc_ff))
      else $error("state-bit exception did not raise unfinished trap");
   chk_state_load: assert property ( // RL12
      wr_status && !cmpl_take ##1 i_rd && i_addr == fes_pkg::ADDR_STATUS
      |=> o_rdata[fes_pkg::CEXC_LSB +: fes_pkg::EXC_W]
          == $past(i_wdata[fes_pkg::CEXC_LSB +: fes_pkg::EXC_W], 2))
      else $error("status load not read back");
   chk_seq_err: assert property ( // RL17
      seq_err |=> o_fp_trap && o_trap_type == fes_pkg::FTT_SEQ
                  && o_rdata == fes_pkg::WORD_ZERO)
      else $error("queue read without entries did not trap");
   chk_qne_absent: assert property ( // RL17
      !QUEUE_EN |-> !o_qne)
      else $error("queue-not-empty set without queue");
   chk_qread_pop: assert property ( // RL15
      q_read && trap_hold_ff && !q_empty |=> count_ff == $past(count_ff) - CNT_ONE)
      else $error("queue read while held did not pop an entry");
   chk_hold_fields: assert property ( // RL18
      trap_hold_ff && !wr_status |=> cexc_ff == $past(cexc_ff) && aexc_ff == $past(aexc_ff))
      else $error("exception fields changed while trap held");

   cov_clean_exc: cover property (clean && exc != fes_pkg::EXC_NONE);
   cov_ieee_trap: cover property (ieee ##1 o_fp_trap);
   cov_queue_pop: cover property (q_read && trap_hold_ff && !q_empty);
   cov_unfin_trap: cover property (unfin ##1 o_fp_trap);
endmodule : fes_status
